// file: pkg/bstp_ctl_if.sv
// Purpose: controls between tap logic and the boundary register
// Assumes: all signals on sys_clk_in
// Notes: strobes are already qualified by the clock enable
`timescale 1ns/1ps
interface bstp_ctl_if #(parameter int N = 8);
	logic tap_rst;
	logic tck_rise;
	logic capture;
	logic shift;
	logic update;
	logic tdi;
	logic so;
	logic [N-1:0] core_val;
	logic [N-1:0] upd_val;

	modport ctl (
		output tap_rst, tck_rise, capture, shift, update, tdi, core_val,
		input so, upd_val
	);
	modport bsr (
		input tap_rst, tck_rise, capture, shift, update, tdi, core_val,
		output so, upd_val
	);
endinterface

// file: pkg/bstp_defs.svh
// Purpose: constants of the boundary-scan test port
// Assumes: included by bare name wherever needed
// Notes: definitions only
`ifndef BSTP_DEFS_SVH
`define BSTP_DEFS_SVH

// =====================================================================
// instruction register
`define BSTP_IR_W 4
`define BSTP_OP_EXTEST 4'h0
`define BSTP_OP_SAMPLE 4'h1
`define BSTP_OP_IDCODE 4'h2
`define BSTP_OP_BYPASS 4'hf
// capture pattern, low two bits 01 as the scan standard asks
`define BSTP_IR_CAPT 4'h1

// =====================================================================
// identification register layout
`define BSTP_ID_W 32
`define BSTP_ID_VER_HI 31
`define BSTP_ID_VER_LO 28
`define BSTP_ID_PART_HI 27
`define BSTP_ID_PART_LO 12
`define BSTP_ID_MFR_HI 11
`define BSTP_ID_MFR_LO 1
`define BSTP_ID_LSB 0
`define BSTP_ID_LSB_VAL 1'b1

// =====================================================================
// boundary chain and pin idle levels
`define BSTP_BS_LEN 8
`define BSTP_PULL_LVL 1'b1
`define BSTP_TCK_IDLE 1'b0

`endif

// file: pkg/bstp_pkg.sv
// Purpose: types shared by the boundary-scan test port
// Assumes: bstp_defs.svh on the include path
// Notes: tap states follow the sixteen-state scan controller
package bstp_pkg;
`include "bstp_defs.svh"

	// =================================================================
	// tap controller states
	typedef enum logic [3:0] {
		TLR, RTI,
		SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} bstp_tap_e;

	typedef logic [`BSTP_IR_W-1:0] bstp_ir_t;
	typedef logic [`BSTP_ID_W-1:0] bstp_id_t;
endpackage

// file: src/bstp_bsr.sv
// Purpose: boundary-scan register, a chain of capture/shift/update cells
// Assumes: strobes are one-cycle pulses on a test clock rising edge
// Notes: update stage holds the value that drives pins in external test
`timescale 1ns/1ps
module bstp_bsr
	import bstp_pkg::*;
#(
	parameter int N = 8
)(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// controls from tap logic
	bstp_ctl_if.bsr ctl
);
	logic [N-1:0] sh_ff;
	logic [N-1:0] upd_ff;
	logic [N:0] chain;

	// =================================================================
	// serial chain, tdi enters at the top, leaves at cell 0
	assign chain[N] = ctl.tdi;
	assign ctl.so = sh_ff[0];
	assign ctl.upd_val = upd_ff;

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_cell
			assign chain[i] = sh_ff[i];
			// one cell: capture core value or shift neighbour
			always_ff @(posedge sys_clk_in)
			begin
				if (rst_in || ctl.tap_rst)
					sh_ff[i] <= 1'b0;
				else if (ctl.tck_rise && ctl.capture)
					sh_ff[i] <= ctl.core_val[i];
				else if (ctl.tck_rise && ctl.shift)
					sh_ff[i] <= chain[i+1];
			end
			// update stage only moves on update, so pins never ripple
			always_ff @(posedge sys_clk_in)
			begin
				if (rst_in || ctl.tap_rst)
					upd_ff[i] <= 1'b0;
				else if (ctl.tck_rise && ctl.update)
					upd_ff[i] <= sh_ff[i];
			end
		end
	endgenerate

	// =================================================================
	// checks
	chk_bsr_shift_path: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ctl.tck_rise && ctl.shift && !ctl.capture && !ctl.tap_rst
		|=> sh_ff[N-1] == $past(ctl.tdi))
		else $error("boundary chain did not take tdi");
endmodule // bstp_bsr

// file: src/bstp_top.sv
// Purpose: boundary-scan test access port, sampled on the system clock
// Assumes: test clock well below half of sys_clk_in; pads carry pull-ups
// Notes: test pins pass two flops; edges of the test clock are found here
//
// Notes on behaviour
// - tms sampled each tck rise steps tap
// - tdi sampled on tck rising edge
// - tdo changes on tck falling edge
// - tdo released when no shift in progress
// - tms, tdi, trst idle high when undriven
// - test reset returns whole scan structure
// - test logic disturbs core path only in external test
// - four-bit instruction register shifts from tdi
// - instruction selects active data register path
// - tms sequence picks instruction or data path
// - public instructions, three data registers only
// - bypass is one flip-flop delay
// - boundary cells chained into one path
// - 32-bit id: version, part, maker, one
`timescale 1ns/1ps
`include "bstp_defs.svh"
module bstp_top
	import bstp_pkg::*;
#(
	// arbitrary identity values, not those of any real part
	parameter logic [3:0] ID_VERSION = 4'h1,
	parameter logic [15:0] ID_PART = 16'h0a5c,
	parameter logic [10:0] ID_MFR = 11'h2a6
)(
	// clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// test pins from the outside controller
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	input wire logic trst_n_in,
	// test data output pin
	output logic tdo_out,
	output logic tdo_oe_n_out,
	// core boundary: core values in, pin values out
	input wire logic [`BSTP_BS_LEN-1:0] core_in,
	output logic [`BSTP_BS_LEN-1:0] pin_out
);
	// =================================================================
	// declarations
	logic [1:0] tck_sy_ff;
	logic [1:0] tms_sy_ff;
	logic [1:0] tdi_sy_ff;
	logic [1:0] trst_sy_ff;
	logic tck_prev_ff;
	bstp_tap_e state_ff;
	bstp_tap_e nxt_state;
	bstp_ir_t ir_sr_ff;
	bstp_ir_t ir_ff;
	bstp_id_t id_sr_ff;
	logic byp_ff;
	logic tdo_ff;
	logic tdo_oe_n_ff;
	logic [`BSTP_BS_LEN-1:0] pin_ff;

	wire tck_s = tck_sy_ff[1];
	wire tms_s = tms_sy_ff[1];
	wire tdi_s = tdi_sy_ff[1];
	wire trst_n_s = trst_sy_ff[1];
	wire tck_rise;
	wire tck_fall;
	wire step;
	wire tap_rst;
	wire sel_id;
	wire sel_bsr;
	wire ext_mode;
	wire dr_so;
	wire shifting;
	bstp_id_t id_val;

	bstp_ctl_if #(.N(`BSTP_BS_LEN)) bs_if ();

	// =================================================================
	// pin synchronisers; reset to idle levels, tck low, the pulled-up pins high
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			tck_sy_ff <= {2{`BSTP_TCK_IDLE}};
			tms_sy_ff <= {2{`BSTP_PULL_LVL}};
			tdi_sy_ff <= {2{`BSTP_PULL_LVL}};
			trst_sy_ff <= {2{`BSTP_PULL_LVL}};
			tck_prev_ff <= `BSTP_TCK_IDLE;
		end
		else if (ce_in)
		begin
			tck_sy_ff <= {tck_sy_ff[0], tck_in};
			tms_sy_ff <= {tms_sy_ff[0], tms_in};
			tdi_sy_ff <= {tdi_sy_ff[0], tdi_in};
			trst_sy_ff <= {trst_sy_ff[0], trst_n_in};
			tck_prev_ff <= tck_s;
		end
	end

	// edges of the test clock; test state moves only on these, apart from test reset
	assign tck_rise = tck_s && !tck_prev_ff;
	assign tck_fall = !tck_s && tck_prev_ff;
	assign step = tck_rise && ce_in;
	assign tap_rst = !trst_n_s && ce_in;

	// =================================================================
	// tap controller next state
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			TLR: nxt_state = tms_s ? TLR : RTI;
			RTI: nxt_state = tms_s ? SEL_DR : RTI;
			SEL_DR: nxt_state = tms_s ? SEL_IR : CAP_DR;
			CAP_DR: nxt_state = tms_s ? EX1_DR : SHF_DR;
			SHF_DR: nxt_state = tms_s ? EX1_DR : SHF_DR;
			EX1_DR: nxt_state = tms_s ? UPD_DR : PAU_DR;
			PAU_DR: nxt_state = tms_s ? EX2_DR : PAU_DR;
			EX2_DR: nxt_state = tms_s ? UPD_DR : SHF_DR;
			UPD_DR: nxt_state = tms_s ? SEL_DR : RTI;
			SEL_IR: nxt_state = tms_s ? TLR : CAP_IR;
			CAP_IR: nxt_state = tms_s ? EX1_IR : SHF_IR;
			SHF_IR: nxt_state = tms_s ? EX1_IR : SHF_IR;
			EX1_IR: nxt_state = tms_s ? UPD_IR : PAU_IR;
			PAU_IR: nxt_state = tms_s ? EX2_IR : PAU_IR;
			EX2_IR: nxt_state = tms_s ? UPD_IR : SHF_IR;
			UPD_IR: nxt_state = tms_s ? SEL_DR : RTI;
		endcase
	end

	// state register; test reset wins over any tck edge
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || tap_rst)
			state_ff <= TLR;
		else if (step)
			state_ff <= nxt_state;
	end

	// =================================================================
	// instruction decode; unknown codes fall back to bypass
	assign sel_id = (ir_ff == `BSTP_OP_IDCODE);
	assign sel_bsr = (ir_ff == `BSTP_OP_EXTEST) || (ir_ff == `BSTP_OP_SAMPLE);
	assign ext_mode = (ir_ff == `BSTP_OP_EXTEST);
	assign shifting = (state_ff == SHF_IR) || (state_ff == SHF_DR);
	assign dr_so = sel_id ? id_sr_ff[0] : (sel_bsr ? bs_if.so : byp_ff);

	// instruction shift register
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || tap_rst)
			ir_sr_ff <= `BSTP_IR_CAPT;
		else if (step && state_ff == CAP_IR)
			ir_sr_ff <= `BSTP_IR_CAPT;
		else if (step && state_ff == SHF_IR)
			ir_sr_ff <= {tdi_s, ir_sr_ff[`BSTP_IR_W-1:1]};
	end

	// current instruction; reset state forces the id instruction
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			ir_ff <= `BSTP_OP_IDCODE;
		else if (ce_in && state_ff == TLR)
			ir_ff <= `BSTP_OP_IDCODE;
		else if (step && state_ff == UPD_IR)
			ir_ff <= ir_sr_ff;
	end

	// =================================================================
	// data registers: bypass and identification
	assign id_val[`BSTP_ID_VER_HI:`BSTP_ID_VER_LO] = ID_VERSION;
	assign id_val[`BSTP_ID_PART_HI:`BSTP_ID_PART_LO] = ID_PART;
	assign id_val[`BSTP_ID_MFR_HI:`BSTP_ID_MFR_LO] = ID_MFR;
	assign id_val[`BSTP_ID_LSB] = `BSTP_ID_LSB_VAL;

	// bypass: single stage, captures zero
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || tap_rst)
			byp_ff <= 1'b0;
		else if (step && state_ff == CAP_DR && !sel_id && !sel_bsr)
			byp_ff <= 1'b0;
		else if (step && state_ff == SHF_DR && !sel_id && !sel_bsr)
			byp_ff <= tdi_s;
	end

	// identification shift register
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || tap_rst)
			id_sr_ff <= '0;
		else if (step && state_ff == CAP_DR && sel_id)
			id_sr_ff <= id_val;
		else if (step && state_ff == SHF_DR && sel_id)
			id_sr_ff <= {tdi_s, id_sr_ff[`BSTP_ID_W-1:1]};
	end

	// =================================================================
	// boundary register
	assign bs_if.tap_rst = tap_rst;
	assign bs_if.tck_rise = step;
	assign bs_if.capture = (state_ff == CAP_DR) && sel_bsr;
	assign bs_if.shift = (state_ff == SHF_DR) && sel_bsr;
	assign bs_if.update = (state_ff == UPD_DR) && sel_bsr;
	assign bs_if.tdi = tdi_s;
	assign bs_if.core_val = core_in;

	bstp_bsr #(.N(`BSTP_BS_LEN)) u_bsr (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ctl(bs_if.bsr)
	);

	// =================================================================
	// tdo moves on the falling edge so the controller samples it on rise
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || tap_rst)
		begin
			tdo_ff <= 1'b0;
			tdo_oe_n_ff <= 1'b1;
		end
		else if (ce_in && tck_fall)
		begin
			tdo_ff <= (state_ff == SHF_IR) ? ir_sr_ff[0] : dr_so;
			tdo_oe_n_ff <= !shifting;
		end
	end

	// pins follow the core unless external test owns them
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			pin_ff <= '0;
		else if (ce_in)
			pin_ff <= ext_mode ? bs_if.upd_val : core_in;
	end

	assign tdo_out = tdo_ff;
	assign tdo_oe_n_out = tdo_oe_n_ff;
	assign pin_out = pin_ff;

	// =================================================================
	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	chk_trst_to_reset: assert property (
		!trst_n_s && ce_in |=> state_ff == TLR && tdo_oe_n_ff)
		else $error("test reset did not reach reset state");

	chk_state_on_rise: assert property (
		$changed(state_ff) |-> $past(step) || $past(tap_rst) || $past(rst_in))
		else $error("tap state moved without a tck rise");

	chk_tdo_on_fall: assert property (
		$changed(tdo_ff) |-> $past(tck_fall && ce_in) || $past(tap_rst))
		else $error("tdo changed off the falling edge");

	chk_tdo_idle_hiz: assert property (
		ce_in && tck_fall && !shifting |=> tdo_oe_n_ff)
		else $error("tdo driven outside a shift");

	chk_ir_shift_in: assert property (
		step && state_ff == SHF_IR && trst_n_s
		|=> ir_sr_ff[`BSTP_IR_W-1] == $past(tdi_s))
		else $error("instruction shift lost tdi");

	chk_ir_default_id: assert property (
		ce_in && state_ff == TLR |=> ir_ff == `BSTP_OP_IDCODE)
		else $error("reset instruction is not id");

	chk_bypass_one_bit: assert property (
		step && state_ff == SHF_DR && !sel_id && !sel_bsr && trst_n_s
		|=> byp_ff == $past(tdi_s))
		else $error("bypass is not a one-bit delay");

	chk_id_capture: assert property (
		step && state_ff == CAP_DR && sel_id && trst_n_s
		|=> id_sr_ff[`BSTP_ID_LSB] == `BSTP_ID_LSB_VAL && id_sr_ff == id_val)
		else $error("id capture wrong");

	chk_core_pass: assert property (
		ce_in && !ext_mode |=> pin_ff == $past(core_in))
		else $error("core path disturbed outside external test");

	chk_tdo_irbit: assert property (
		ce_in && tck_fall && state_ff == SHF_IR && trst_n_s
		|=> tdo_ff == $past(ir_sr_ff[0]) && !tdo_oe_n_ff)
		else $error("tdo not from instruction register");

	chk_id_shift_in: assert property (
		step && state_ff == SHF_DR && sel_id && trst_n_s
		|=> id_sr_ff[`BSTP_ID_W-1] == $past(tdi_s))
		else $error("id shift lost tdi");

	chk_ir_update: assert property (
		step && state_ff == UPD_IR |=> ir_ff == $past(ir_sr_ff))
		else $error("instruction not loaded on update");

	chk_pins_extest: assert property (
		ce_in && ext_mode |=> pin_ff == $past(bs_if.upd_val))
		else $error("external test pins not from update stage");
endmodule // bstp_top

// file: test/bstp_ctrl_model.sv
// Purpose: outside test controller driving the scan port pins
// Assumes: paced by the system clock; one test clock period is 8 system cycles
// Notes: test clock stands still between steps; tdo is read late in the high phase
`timescale 1ns/1ps
module bstp_ctrl_model (
	// pacing clock
	input wire logic sys_clk_in,
	// test pins towards the device
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	output logic trst_n_out,
	// test data back from the device
	input wire logic tdo_in,
	input wire logic tdo_oe_n_in
);
	logic tdo_seen;
	logic oe_n_seen;

	// =================================================================
	// power-up levels
	// test reset held low until the bench lets go of it
	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
		trst_n_out = 1'b0;
	end

	// =================================================================
	// pin tasks
	// test reset level, changed just after a system edge
	task automatic set_trst(input logic v);
		@(posedge sys_clk_in);
		trst_n_out <= v;
	endtask

	// one test clock period: 80 ns low, then 80 ns high
	task automatic step(input logic m, input logic d);
		@(posedge sys_clk_in);
		tck_out <= 1'b0;
		tms_out <= m;
		tdi_out <= d;
		repeat (4) @(posedge sys_clk_in);
		tck_out <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		// late in the high phase, so a value launched by the fall has settled
		@(negedge sys_clk_in);
		// a released pin shows the inverse of tdo_in, which is refreshed on every fall even while released
		tdo_seen = tdo_oe_n_in ? !tdo_in : tdo_in;
		oe_n_seen = tdo_oe_n_in;
	endtask
endmodule // bstp_ctrl_model

// file: test/test_boundary_scan_test_port.sv
// Purpose: self-checking bench of the scan test port
// Assumes: controller model paces the test clock at 160 ns
// Notes: scans shift lsb first; expectations are built from fixed patterns
`timescale 1ns/1ps
`include "bstp_defs.svh"
module test_boundary_scan_test_port;
	// arbitrary identity values, handed to the device
	localparam logic [3:0] VER = 4'h1;
	localparam logic [15:0] PART = 16'h0a5c;
	localparam logic [10:0] MFR = 11'h2a6;
	localparam logic [31:0] ID_EXP = {VER, PART, MFR, `BSTP_ID_LSB_VAL};

	logic sys_clk;
	logic rst;
	logic ce;
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;
	logic tdo;
	logic tdo_oe_n;
	logic [7:0] core;
	logic [7:0] pin;
	int n_fail = 0;
	int checked = 0;

	// =================================================================
	// clock and instances
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	bstp_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) dut (
		.sys_clk_in(sys_clk), .rst_in(rst), .ce_in(ce),
		.tck_in(tck), .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n),
		.tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .core_in(core), .pin_out(pin)
	);

	bstp_ctrl_model u_ctl (
		.sys_clk_in(sys_clk), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.trst_n_out(trst_n), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n)
	);

	// =================================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// test reset pulse; tap then steps from its reset state to idle
	task automatic trst_pulse();
		u_ctl.set_trst(1'b0);
		repeat (6) @(posedge sys_clk);
		u_ctl.set_trst(1'b1);
		repeat (6) @(posedge sys_clk);
		chk({31'h0, tdo_oe_n}, 32'h1);
		u_ctl.step(1'b0, 1'b1);
	endtask

	// one scan from idle back to idle; ir picks the instruction path
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		dout = 32'h0;
		u_ctl.step(1'b1, 1'b1);
		if (ir)
			u_ctl.step(1'b1, 1'b1);
		u_ctl.step(1'b0, 1'b1);
		u_ctl.step(1'b0, 1'b1);
		chk({31'h0, u_ctl.oe_n_seen}, 32'h1);
		for (int i = 0; i < n; i++)
		begin
			u_ctl.step(i == n - 1, din[i]);
			dout[i] = u_ctl.tdo_seen;
			if (i == 0)
				chk({31'h0, u_ctl.oe_n_seen}, 32'h0);
		end
		u_ctl.step(1'b1, 1'b1);
		chk({31'h0, u_ctl.oe_n_seen}, 32'h1);
		u_ctl.step(1'b0, 1'b1);
	endtask

	// =================================================================
	// scenarios
	task automatic t_idcode();
		logic [31:0] d;
		trst_pulse();
		scan(1'b0, 32, 32'hffffffff, d);
		chk(d, ID_EXP);
	endtask

	task automatic t_ir_capture();
		logic [31:0] d;
		scan(1'b1, 4, {28'h0, `BSTP_OP_BYPASS}, d);
		chk({28'h0, d[3:0]}, {28'h0, `BSTP_IR_CAPT});
	endtask

	// unknown opcodes must behave as bypass: one stage, capturing zero
	task automatic t_bypass(input logic [3:0] op);
		logic [31:0] d;
		scan(1'b1, 4, {28'h0, op}, d);
		scan(1'b0, 8, 32'hb4, d);
		chk({24'h0, d[7:0]}, 32'h68);
	endtask

	// sample, preload, then drive the pins from the update stage
	task automatic t_boundary();
		logic [31:0] d;
		@(posedge sys_clk);
		core <= 8'h5a;
		scan(1'b1, 4, {28'h0, `BSTP_OP_SAMPLE}, d);
		chk({24'h0, pin}, 32'h5a);
		scan(1'b0, 8, 32'hc3, d);
		chk({24'h0, d[7:0]}, 32'h5a);
		scan(1'b1, 4, {28'h0, `BSTP_OP_EXTEST}, d);
		@(posedge sys_clk);
		core <= 8'h0f;
		repeat (3) @(posedge sys_clk);
		chk({24'h0, pin}, 32'hc3);
	endtask

	// reset in mid instruction shift restores identification path
	task automatic t_trst_mid();
		logic [31:0] d;
		u_ctl.step(1'b1, 1'b1);
		u_ctl.step(1'b1, 1'b1);
		u_ctl.step(1'b0, 1'b1);
		u_ctl.step(1'b0, 1'b1);
		u_ctl.step(1'b0, 1'b0);
		trst_pulse();
		chk({24'h0, pin}, 32'h0f);
		scan(1'b0, 32, 32'h0, d);
		chk(d, ID_EXP);
	endtask

	// clock enable low freezes the port: a whole tck step and a core change go unseen
	task automatic t_ce_freeze();
		logic [31:0] d;
		@(posedge sys_clk);
		ce <= 1'b0;
		core <= 8'ha5;
		u_ctl.step(1'b1, 1'b1);
		@(posedge sys_clk);
		chk({24'h0, pin}, 32'h0f);
		ce <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({24'h0, pin}, 32'ha5);
		scan(1'b0, 32, 32'h0, d);
		chk(d, ID_EXP);
	endtask

	// five ones on tms reach the reset state from anywhere
	task automatic t_tms_reset();
		logic [31:0] d;
		scan(1'b1, 4, {28'h0, `BSTP_OP_BYPASS}, d);
		repeat (5) u_ctl.step(1'b1, 1'b1);
		u_ctl.step(1'b0, 1'b1);
		scan(1'b0, 32, 32'h0, d);
		chk(d, ID_EXP);
	endtask

	// =================================================================
	// main sequence and watchdog
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		core = 8'h00;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_idcode();
		t_ir_capture();
		t_bypass(`BSTP_OP_BYPASS);
		t_bypass(4'h5);
		t_boundary();
		t_trst_mid();
		t_ce_freeze();
		t_tms_reset();
		summarize();
	end

	// about 260 test clock steps are expected; allow ample margin
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		summarize();
	end
endmodule // test_boundary_scan_test_port
